// [design/irq_redirection_entry_low.sv]
// Redirection table of 24 entries with delivery request arbitration.
// Assumes an index/window register pair and a message path that answers
// each send with accepted or busy in the cycle it is offered.
`timescale 1ns/1ps
module irq_redirection_entry_low
  import redir_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [N-1:0] irq_pin,
  input  wire logic [7:0]   index,
  input  wire logic         window_wr,
  input  wire logic         window_rd,
  input  wire logic [31:0]  window_wdata,
  output logic [31:0]       window_rdata,
  input  wire logic         end_of_interrupt_wr,
  input  wire logic [7:0]   end_of_interrupt_vector,
  output logic              msg_valid,
  output logic [7:0]        msg_interrupt_vector,
  output logic [2:0]        msg_delivery_kind,
  output logic              msg_destination_addressing,
  output logic              msg_level,
  output logic [7:0]        msg_destination,
  output logic [7:0]        msg_ext_destination,
  output logic [4:0]        msg_source,
  input  wire logic         msg_accept,
  input  wire logic         msg_busy
);
  logic [31:0] redirection_entry_low_ff  [N];
  logic [31:0] redirection_entry_high_ff [N];
  logic [N-1:0] request;
  logic [N-1:0] eoi_hit;
  logic [N-1:0] sent;
  logic         idx_entry;
  logic [4:0]   idx_sel;
  logic         idx_high;
  logic [4:0]   cur;
  logic         found;
  logic [4:0]   pick;
  logic         accepted;

  // Index decode: 10h..3Fh, even word low, odd word high
  assign idx_entry = (index >= ENTRY_BASE_IDX) && (index <= (ENTRY_LAST_IDX + 8'h01));
  assign idx_sel   = 5'((index - ENTRY_BASE_IDX) >> 1);
  assign idx_high  = index[0];
  assign cur       = msg_source;
  assign accepted  = msg_valid && msg_accept;

  always_comb begin
    found = 1'b0;
    pick  = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (request[i]) begin
        found = 1'b1;
        pick  = 5'(i);
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gen_in
      irq_sense u_sense (
        .clk        (clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .pin        (irq_pin[g]),
        .polarity   (redirection_entry_low_ff[g][BIT_POLARITY]),
        .level_mode (redirection_entry_low_ff[g][BIT_TRIGGER]),
        .masked     (redirection_entry_low_ff[g][BIT_MASK]),
        .remote     (redirection_entry_low_ff[g][BIT_REMOTE]),
        .sent       (sent[g]),
        .request    (request[g])
      );
      vec_match u_match (
        .eoi_valid    (end_of_interrupt_wr),
        .eoi_vector   (end_of_interrupt_vector),
        .entry_vector (redirection_entry_low_ff[g][7:0]),
        .hit          (eoi_hit[g])
      );
      assign sent[g] = accepted && (cur == 5'(g));
    end
  endgenerate

  // Low words: software fields, remote-acceptance and delivery status
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        redirection_entry_low_ff[i] <= ENTRY_LOW_RESET;
      end
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (window_wr && idx_entry && !idx_high && idx_sel == 5'(i)) begin
          // Bit 17 stored only; 14 and 12 kept from hardware
          redirection_entry_low_ff[i] <= (window_wdata & LOW_WRITE_MASK)
            | (redirection_entry_low_ff[i] & ~LOW_WRITE_MASK);
        end
        // Acceptance wins over a same-cycle end-of-interrupt
        if (eoi_hit[i]) begin
          redirection_entry_low_ff[i][BIT_REMOTE] <= 1'b0;
        end
        if (sent[i] && msg_level) begin
          redirection_entry_low_ff[i][BIT_REMOTE] <= 1'b1;
        end
        if (msg_valid && cur == 5'(i)) begin
          redirection_entry_low_ff[i][BIT_PENDING] <= msg_busy && !msg_accept;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N; i++) begin
        redirection_entry_high_ff[i] <= ENTRY_HIGH_RESET;
      end
    end else if (ce) begin
      for (int i = 0; i < N; i++) begin
        if (window_wr && idx_entry && idx_high && idx_sel == 5'(i)) begin
          redirection_entry_high_ff[i] <= window_wdata & HIGH_WRITE_MASK;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      window_rdata <= '0;
    end else if (ce && window_rd) begin
      if (idx_entry) begin
        window_rdata <= idx_high ? redirection_entry_high_ff[idx_sel]
                                 : redirection_entry_low_ff[idx_sel];
      end else begin
        window_rdata <= '0;
      end
    end
  end

  // Message offer: held until accepted; a busy answer retries the same entry.
  // Once offered, a later mask does not withdraw an accepted message.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      msg_valid                  <= 1'b0;
      msg_source                 <= '0;
      msg_interrupt_vector       <= '0;
      msg_delivery_kind          <= '0;
      msg_destination_addressing <= 1'b0;
      msg_level                  <= 1'b0;
      msg_destination            <= '0;
      msg_ext_destination        <= '0;
    end else if (ce) begin
      if (msg_valid && msg_accept) begin
        msg_valid <= 1'b0;
      end else if (!msg_valid && found) begin
        msg_valid                  <= 1'b1;
        msg_source                 <= pick;
        msg_interrupt_vector       <= redirection_entry_low_ff[pick][7:0];
        msg_delivery_kind          <= redirection_entry_low_ff[pick][KIND_LSB +: 3];
        msg_destination_addressing <= redirection_entry_low_ff[pick][BIT_DEST_MODE];
        msg_level                  <= redirection_entry_low_ff[pick][BIT_TRIGGER];
        // Physical mode uses the low nibble only
        msg_destination <= redirection_entry_low_ff[pick][BIT_DEST_MODE]
          ? redirection_entry_high_ff[pick][31:24]
          : {4'h0, redirection_entry_high_ff[pick][27:24]};
        msg_ext_destination <= redirection_entry_high_ff[pick][23:16];
      end
    end
  end
endmodule : irq_redirection_entry_low

// [design/redir_pkg.sv]
// Constants shared by the redirection entry block.
// Assumes a single core clock and an indirect index/window register pair.
// Operation
// - One low-word entry per input, input 0 at index 10h, step two, last 3Eh.
// - Each low word resets to 00010000h: masked, all other fields clear.
// - Entry fields form the message sent to a local interrupt controller.
// - Bit 17 is plain storage and never triggers any flushing.
// - Unmasked input with active edge or level gets delivered.
// - Masked input is neither delivered nor remembered as pending.
// - Masking after acceptance leaves the accepted interrupt alone.
// - Bit 15 selects edge (0) or level (1) sensing.
// - Level input sets read-only bit 14 when the controller accepts it.
// - End-of-interrupt message clears the remote-acceptance bit.
// - Bit 13 selects active high (0) or active low (1).
// - Delivery status bit 12 is read-only; writes leave it.
// - Delivery status is 0 idle, 1 while held for a busy receiver.
// - Destination mode 0 is physical, id from combined bits 59:56.
// - Destination mode 1 is logical, combined bits 63:56 matched.
// - Delivery kinds 000 fixed and 001 lowest priority; others unsupported; the block forwards all eight kinds unchanged.
// - End-of-interrupt write clears remote-acceptance of every matching vector.
package redir_pkg;
  localparam int          NUM_INPUTS       = 24;
  localparam logic [7:0]  ENTRY_BASE_IDX   = 8'h10;
  localparam logic [7:0]  ENTRY_LAST_IDX   = 8'h3e;
  localparam logic [31:0] ENTRY_LOW_RESET  = 32'h0001_0000;
  localparam logic [31:0] ENTRY_HIGH_RESET = 32'h0000_0000;
  localparam int          BIT_FLUSH_DIS    = 17;
  localparam int          BIT_MASK         = 16;
  localparam int          BIT_TRIGGER      = 15;
  localparam int          BIT_REMOTE       = 14;
  localparam int          BIT_POLARITY     = 13;
  localparam int          BIT_PENDING      = 12;
  localparam int          BIT_DEST_MODE    = 11;
  localparam int          KIND_LSB         = 8;
  localparam logic [2:0]  KIND_FIXED       = 3'h0;
  localparam logic [2:0]  KIND_LOWEST      = 3'h1;
  localparam logic [31:0] LOW_WRITE_MASK   = 32'h0003_afff;
  localparam logic [31:0] HIGH_WRITE_MASK  = 32'hffff_0000;
endpackage : redir_pkg

// [design/irq_sense.sv]
// Per-input sensing: polarity, edge or level trigger, request hold.
// Assumes the pin is synchronous to clk.
`timescale 1ns/1ps
module irq_sense
  import redir_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic polarity,
  input  wire logic level_mode,
  input  wire logic masked,
  input  wire logic remote,
  input  wire logic sent,
  output logic      request
);
  logic active;
  logic prev_ff;
  logic edge_hold_ff;

  assign active = pin ^ polarity;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_ff <= 1'b0;
    end else if (ce) begin
      prev_ff <= active;
    end
  end

  // Edge remembered until sent; a mask drops it rather than keeping it pending
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_hold_ff <= 1'b0;
    end else if (ce) begin
      if (masked || level_mode) begin
        edge_hold_ff <= 1'b0;
      end else if (active && !prev_ff) begin
        edge_hold_ff <= 1'b1;
      end else if (sent) begin
        edge_hold_ff <= 1'b0;
      end
    end
  end

  assign request = !masked && (level_mode ? (active && !remote) : edge_hold_ff);
endmodule : irq_sense

// [design/vec_match.sv]
// Compares an end-of-interrupt vector to one entry's vector.
// Assumes the strobe is one cycle wide.
`timescale 1ns/1ps
module vec_match (
  input  wire logic       eoi_valid,
  input  wire logic [7:0] eoi_vector,
  input  wire logic [7:0] entry_vector,
  output logic            hit
);
  assign hit = eoi_valid && (eoi_vector == entry_vector);
endmodule : vec_match

// [test/redir_monitor.sv]
// Port-level checker for the redirection entry block.
// Assumes one clock domain; bound from the bench top file.
`timescale 1ns/1ps
module redir_monitor
  import redir_pkg::*;
#(
  parameter int N = NUM_INPUTS
) (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  index,
  input wire logic        window_rd,
  input wire logic [31:0] window_rdata,
  input wire logic        msg_valid,
  input wire logic [7:0]  msg_interrupt_vector,
  input wire logic        msg_destination_addressing,
  input wire logic [7:0]  msg_destination,
  input wire logic [4:0]  msg_source,
  input wire logic        msg_level,
  input wire logic        msg_accept,
  input wire logic        msg_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_HOLD: assert property (msg_valid && !(ce && msg_accept) |=> msg_valid)
    else $error("message dropped before accept");
  AST_STABLE: assert property (msg_valid && !(ce && msg_accept) |=>
    $stable(msg_interrupt_vector) && $stable(msg_source)) else $error("fields moved");
  AST_GAP: assert property (msg_valid && ce && msg_accept |=> !msg_valid)
    else $error("no gap after accept");
  AST_SRC: assert property (msg_valid |-> msg_source < N)
    else $error("source out of range");
  AST_PHYS: assert property (msg_valid && !msg_destination_addressing |->
    msg_destination[7:4] == 4'h0) else $error("physical id too wide");
  AST_OUT: assert property (ce && window_rd && (index < 8'h10 || index > 8'h3f) |=>
    window_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  AST_LOW: assert property (ce && window_rd && index inside {[8'h10:8'h3f]} && !index[0]
    |=> window_rdata[31:18] == 14'h0000) else $error("reserved bits set");
  AST_RD: assert property (!(ce && window_rd) |=> $stable(window_rdata))
    else $error("read data moved without read");
  cover property (msg_valid && msg_busy);
  cover property (msg_valid && msg_accept && msg_level);
  cover property (ce && window_rd && index == 8'h40);
endmodule : redir_monitor

// [test/local_ctrl_model.sv]
// Local controller stand-in: stays busy for hold cycles, then accepts.
// Assumes msg_valid stays up until accepted.
`timescale 1ns/1ps
module local_ctrl_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       msg_valid,
  input  wire logic [3:0] hold,
  output logic            msg_accept,
  output logic            msg_busy
);
  logic [3:0] wait_ff;
  // Answer in the offer cycle, as the block samples both together
  assign msg_busy   = msg_valid && (wait_ff < hold);
  assign msg_accept = msg_valid && !msg_busy;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wait_ff <= 4'h0;
    else if (msg_accept) wait_ff <= 4'h0;
    else if (msg_busy) wait_ff <= wait_ff + 4'h1;
  end
endmodule : local_ctrl_model

// [test/irq_redirection_entry_low_test.sv]
// Bench: window register access, message delivery, end of interrupt.
// Assumes ce high except for one frozen write, stand-in controller on the message port.
`timescale 1ns/1ps
module irq_redirection_entry_low_test;
  import redir_pkg::*;
  logic clk = 0, rst_n = 0, ce = 1, window_wr = 0, window_rd = 0, end_of_interrupt_wr = 0;
  logic [NUM_INPUTS-1:0] irq_pin = '0;
  logic [7:0]  index = 8'h00, end_of_interrupt_vector = 8'h00;
  logic [31:0] window_wdata = 32'h0000_0000, window_rdata;
  logic [7:0]  msg_interrupt_vector, msg_destination, msg_ext_destination;
  logic [2:0]  msg_delivery_kind;
  logic [4:0]  msg_source;
  logic        msg_valid, msg_destination_addressing, msg_level, msg_accept, msg_busy;
  logic [3:0]  hold = 4'h0;
  int          miscompares = 0, n_checks = 0;
  always #12.5 clk = ~clk;
  irq_redirection_entry_low uut (.clk, .rst_n, .ce, .irq_pin, .index, .window_wr, .window_rd,
    .window_wdata, .window_rdata, .end_of_interrupt_wr, .end_of_interrupt_vector, .msg_valid,
    .msg_interrupt_vector, .msg_delivery_kind, .msg_destination_addressing, .msg_level,
    .msg_destination, .msg_ext_destination, .msg_source, .msg_accept, .msg_busy);
  local_ctrl_model peer (.clk, .rst_n, .msg_valid, .hold, .msg_accept, .msg_busy);
  task automatic tally_and_finish();
    if (miscompares == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    index <= a;
    window_wdata <= d;
    window_wr <= 1'b1;
    @(posedge clk);
    window_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    index <= a;
    window_rd <= 1'b1;
    @(posedge clk);
    window_rd <= 1'b0;
    @(posedge clk);
    #1 chk(window_rdata, exp, "rdata");
  endtask : rd
  task automatic pin(input int b, input logic v);
    @(posedge clk);
    irq_pin[b] <= v;
  endtask : pin
  task automatic end_of_interrupt(input logic [7:0] v);
    @(posedge clk);
    end_of_interrupt_wr <= 1'b1;
    end_of_interrupt_vector <= v;
    @(posedge clk);
    end_of_interrupt_wr <= 1'b0;
  endtask : end_of_interrupt
  task automatic quiet(input int n);
    repeat (n) begin
      @(posedge clk);
      #1 chk(msg_valid, 1'b0, "quiet");
    end
  endtask : quiet
  task automatic expect_msg(input logic [4:0] src, input logic [7:0] vec, input logic lvl,
                            input logic [2:0] kind, input logic dm, input logic [7:0] dst,
                            input logic [7:0] ext);
    int i;
    for (i = 0; i < 30 && msg_valid !== 1'b1; i++) @(posedge clk) #1;
    chk(msg_valid, 1'b1, "valid");
    if (msg_valid !== 1'b1) tally_and_finish();
    chk(msg_source, src, "source");
    chk(msg_interrupt_vector, vec, "vector");
    chk(msg_level, lvl, "level");
    chk(msg_delivery_kind, kind, "kind");
    chk(msg_destination, dst, "dest");
    chk(msg_destination_addressing, dm, "dest mode");
    chk(msg_ext_destination, ext, "ext dest");
    for (i = 0; i < 30 && msg_valid === 1'b1; i++) @(posedge clk) #1;
    chk(msg_valid, 1'b0, "released");
    if (msg_valid !== 1'b0) tally_and_finish();
  endtask : expect_msg
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_INPUTS; i++) rd(8'h10 + 8'(2 * i), 32'h0001_0000);
    rd(8'h40, 32'h0000_0000);
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h12, 32'h0000_0055);
    ce <= 1'b1;
    rd(8'h12, 32'h0001_0000);
    wr(8'h10, 32'hffff_ffff);
    rd(8'h10, 32'h0003_afff);
    pin(3, 1'b1);
    pin(3, 1'b0);
    quiet(6);
    wr(8'h16, 32'h0000_0040);
    quiet(6);
    wr(8'h15, 32'ha55a_ffff);
    rd(8'h15, 32'ha55a_0000);
    for (int k = 0; k < 8; k++) begin
      wr(8'h14, {20'h0_0000, k[0], 3'(k), 8'h20});
      if (k == 7) hold <= 4'h6;
      pin(2, 1'b1);
      pin(2, 1'b0);
      if (k == 7) begin
        @(posedge clk);
        rd(8'h14, 32'h0000_1f20);
      end
      expect_msg(5'h02, 8'h20, 1'b0, 3'(k), k[0], k[0] ? 8'ha5 : 8'h05,
                 8'h5a);
    end
    rd(8'h14, 32'h0000_0f20);
    hold <= 4'h0;
    pin(5, 1'b1);
    wr(8'h1a, 32'h0000_a030);
    quiet(4);
    pin(5, 1'b0);
    expect_msg(5'h05, 8'h30, 1'b1, 3'h0, 1'b0, 8'h00, 8'h00);
    rd(8'h1a, 32'h0000_e030);
    quiet(10);
    end_of_interrupt(8'h30);
    expect_msg(5'h05, 8'h30, 1'b1, 3'h0, 1'b0, 8'h00, 8'h00);
    wr(8'h1a, 32'h0001_a030);
    rd(8'h1a, 32'h0001_e030);
    end_of_interrupt(8'h30);
    rd(8'h1a, 32'h0001_a030);
    quiet(6);
    tally_and_finish();
  end
endmodule : irq_redirection_entry_low_test
bind irq_redirection_entry_low redir_monitor #(.N(N)) mon (.clk, .rst_n, .ce, .index,
  .window_rd, .window_rdata, .msg_valid, .msg_interrupt_vector, .msg_destination_addressing,
  .msg_destination, .msg_source, .msg_level, .msg_accept, .msg_busy);
